/* verilog/dbecc_pkg.sv */
package dbecc_pkg;
  // Register byte offsets
  localparam logic [7:0] RAW_STATUS_OFS  = 8'h00;
  localparam logic [7:0] MASKED_STAT_OFS = 8'h04;
  localparam logic [7:0] ENABLE_SET_OFS  = 8'h08;
  localparam logic [7:0] ENABLE_CLR_OFS  = 8'h0C;
  localparam logic [7:0] ADDR_LOG_OFS    = 8'h10;
  localparam logic [7:0] ERR_COUNT_OFS   = 8'h14;
  // Field positions
  localparam int DBL_ERR_BIT = 4;
  // Reset values
  localparam logic [31:0] ADDR_LOG_RESET = 32'h0000_0000;
  localparam logic        ENABLE_RESET   = 1'b0;
  // Response status codes
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h3;
  // Depth of the read-response queue
  localparam int RESP_SLOTS = 32;
endpackage : dbecc_pkg

/* verilog/dbecc_resp_mem.sv */
`timescale 1ns/1ps
// Slot storage for read responses; registered read port
module dbecc_resp_mem #(
  parameter int WIDTH = 35,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic             clk,
  input  wire logic             ce,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic             re,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  // Each slot is written only through its own address
  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && re) begin
      rdata <= mem[raddr];
    end
  end
endmodule : dbecc_resp_mem

/* verilog/dbecc_report.sv */
`timescale 1ns/1ps
module dbecc_report #(
  parameter int DATA_W = 32,
  parameter int DEPTH  = dbecc_pkg::RESP_SLOTS,
  parameter int AW     = $clog2(dbecc_pkg::RESP_SLOTS)
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              ce,
  // Read results from the memory core
  input  wire logic              rd_valid,
  output logic                   rd_ready,
  input  wire logic [DATA_W-1:0] rd_data,
  input  wire logic [31:0]       rd_addr,
  input  wire logic              rd_double_err,
  // Response toward the requesting master
  output logic                   resp_valid,
  input  wire logic              resp_ready,
  output logic      [DATA_W-1:0] resp_data,
  output logic      [1:0]        resp_status,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  output logic                   err_irq
);
  localparam int W = DATA_W + 1;

  logic [AW-1:0]  wr_ptr_reg;
  logic [AW-1:0]  rd_ptr_reg;
  logic [AW:0]    count_reg;
  logic [AW:0]    held;
  logic           out_valid_reg;
  logic [W-1:0]   mem_rdata;
  logic           raw_flag_reg;
  logic           enable_reg;
  logic [31:0]    addr_log_reg;
  logic [15:0]    err_count_reg;
  logic           ack_reg;
  logic [31:0]    dat_o_reg;
  logic           push;
  logic           pop;
  logic           load_out;
  logic           wb_req;
  logic           wb_wr;
  logic           clear_flag;

  // Queue handshakes; the output register refills when empty or taken.
  // The output stage counts as a slot, so never more than 32 responses are held
  assign held       = count_reg + (AW+1)'(out_valid_reg);
  assign rd_ready   = (held < (AW+1)'(DEPTH));
  assign push       = rd_valid && rd_ready;
  assign load_out   = (count_reg != '0) && (!out_valid_reg || resp_ready);
  assign pop        = load_out;
  assign resp_valid = out_valid_reg;

  // Status word per slot: error bit stored with the slot's own data
  dbecc_resp_mem #(
    .WIDTH (W),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_mem (
    .clk   (clk),
    .ce    (ce),
    .we    (push),
    .waddr (wr_ptr_reg),
    .wdata ({rd_double_err, rd_data}),
    .re    (pop),
    .raddr (rd_ptr_reg),
    .rdata (mem_rdata)
  );

  // Round-robin slot pointers wrap naturally through all 32 slots
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (ce) begin
      if (push) wr_ptr_reg <= wr_ptr_reg + AW'(1);
      if (pop)  rd_ptr_reg <= rd_ptr_reg + AW'(1);
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Output stage valid tracks the registered memory read
  always_ff @(posedge clk) begin
    if (reset) begin
      out_valid_reg <= 1'b0;
    end else if (ce) begin
      if (load_out) out_valid_reg <= 1'b1;
      else if (resp_ready) out_valid_reg <= 1'b0;
    end
  end

  // Data and status leave together from the same slot word
  assign resp_data   = mem_rdata[DATA_W-1:0];
  assign resp_status = mem_rdata[DATA_W] ? dbecc_pkg::RESP_ERR : dbecc_pkg::RESP_OK;

  // Bus decode
  assign wb_req     = wb_cyc_i && wb_stb_i && !ack_reg;
  // A write lands at the edge at which the master sees ack, never earlier
  assign wb_wr      = wb_cyc_i && wb_stb_i && ack_reg && wb_we_i && wb_sel_i[0];
  assign clear_flag = wb_wr && (wb_adr_i == dbecc_pkg::RAW_STATUS_OFS)
                      && wb_dat_i[dbecc_pkg::DBL_ERR_BIT];

  // Sticky error flag: a new error beats a write-one-to-clear
  always_ff @(posedge clk) begin
    if (reset) begin
      raw_flag_reg <= 1'b0;
    end else if (ce) begin
      if (push && rd_double_err) raw_flag_reg <= 1'b1;
      else if (clear_flag) raw_flag_reg <= 1'b0;
    end
  end

  // Address of the latest failing read
  always_ff @(posedge clk) begin
    if (reset) begin
      addr_log_reg  <= dbecc_pkg::ADDR_LOG_RESET;
      err_count_reg <= '0;
    end else if (ce && push && rd_double_err) begin
      addr_log_reg  <= rd_addr;
      err_count_reg <= (err_count_reg == 16'hFFFF) ? err_count_reg : err_count_reg + 16'h0001;
    end
  end

  // Interrupt enable, set and clear registers; recommended on
  always_ff @(posedge clk) begin
    if (reset) begin
      enable_reg <= dbecc_pkg::ENABLE_RESET;
    end else if (ce && wb_wr && wb_dat_i[dbecc_pkg::DBL_ERR_BIT]) begin
      if (wb_adr_i == dbecc_pkg::ENABLE_SET_OFS) enable_reg <= 1'b1;
      else if (wb_adr_i == dbecc_pkg::ENABLE_CLR_OFS) enable_reg <= 1'b0;
    end
  end

  assign err_irq = raw_flag_reg && enable_reg;

  // Read mux and one-cycle ack; unmapped reads return zero
  always_ff @(posedge clk) begin
    if (reset) begin
      ack_reg   <= 1'b0;
      dat_o_reg <= 32'h0000_0000;
    end else if (ce) begin
      ack_reg   <= wb_req;
      dat_o_reg <= 32'h0000_0000;
      if (wb_req && !wb_we_i) begin
        if (wb_adr_i == dbecc_pkg::RAW_STATUS_OFS)
          dat_o_reg[dbecc_pkg::DBL_ERR_BIT] <= raw_flag_reg;
        else if (wb_adr_i == dbecc_pkg::MASKED_STAT_OFS)
          dat_o_reg[dbecc_pkg::DBL_ERR_BIT] <= raw_flag_reg && enable_reg;
        else if (wb_adr_i == dbecc_pkg::ENABLE_SET_OFS ||
                 wb_adr_i == dbecc_pkg::ENABLE_CLR_OFS)
          dat_o_reg[dbecc_pkg::DBL_ERR_BIT] <= enable_reg;
        else if (wb_adr_i == dbecc_pkg::ADDR_LOG_OFS)
          dat_o_reg <= addr_log_reg;
        else if (wb_adr_i == dbecc_pkg::ERR_COUNT_OFS)
          dat_o_reg <= {16'h0000, err_count_reg};
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_o_reg;

  // Checks on error recording
  flag_sets_a: assert property (@(posedge clk) disable iff (reset)
    ce && push && rd_double_err |=> raw_flag_reg)
    else $error("error flag not set");
  clear_flag_a: assert property (@(posedge clk) disable iff (reset)
    ce && clear_flag && !(push && rd_double_err) |=> !raw_flag_reg)
    else $error("error flag not cleared");
  irq_follows_a: assert property (@(posedge clk) disable iff (reset)
    ce && push && rd_double_err && enable_reg |=> err_irq)
    else $error("interrupt not raised");
  log_captures_a: assert property (@(posedge clk) disable iff (reset)
    ce && push && rd_double_err |=> addr_log_reg == $past(rd_addr))
    else $error("address not logged");
  log_keeps_a: assert property (@(posedge clk) disable iff (reset)
    !(ce && push && rd_double_err) |=> $stable(addr_log_reg))
    else $error("address log changed");
  // Checks on the response queue
  ptr_steps_a: assert property (@(posedge clk) disable iff (reset)
    ce && push |=> wr_ptr_reg == $past(wr_ptr_reg) + AW'(1))
    else $error("slot order broken");
  read_order_a: assert property (@(posedge clk) disable iff (reset)
    ce && pop |=> rd_ptr_reg == $past(rd_ptr_reg) + AW'(1))
    else $error("read order broken");
  no_overfill_a: assert property (@(posedge clk) disable iff (reset)
    held <= (AW+1)'(DEPTH))
    else $error("queue overfilled");
  resp_load_a: assert property (@(posedge clk) disable iff (reset)
    ce && load_out |=> resp_valid)
    else $error("response not presented");
  resp_holds_a: assert property (@(posedge clk) disable iff (reset)
    ce && resp_valid && !resp_ready |=> resp_valid && $stable(resp_data)
                                        && $stable(resp_status))
    else $error("response changed before taken");
  // Checks on the register bus
  masked_bit_a: assert property (@(posedge clk) disable iff (reset)
    ce && wb_req && !wb_we_i && wb_adr_i == dbecc_pkg::MASKED_STAT_OFS
    |=> wb_dat_o[dbecc_pkg::DBL_ERR_BIT] == $past(err_irq))
    else $error("masked status wrong");
  enable_set_a: assert property (@(posedge clk) disable iff (reset)
    ce && wb_wr && wb_adr_i == dbecc_pkg::ENABLE_SET_OFS
    && wb_dat_i[dbecc_pkg::DBL_ERR_BIT] |=> enable_reg)
    else $error("enable not set");
  ack_pulse_a: assert property (@(posedge clk) disable iff (reset)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held");

  // Main scenarios
  full_cov: cover property (@(posedge clk) held == (AW+1)'(DEPTH));
  wrap_cov: cover property (@(posedge clk) ce && push && wr_ptr_reg == '1);
  err_cov: cover property (@(posedge clk) resp_valid && resp_status == dbecc_pkg::RESP_ERR);
  irq_cov: cover property (@(posedge clk) err_irq);
endmodule : dbecc_report

/* verification/dbecc_master_model.sv */
`timescale 1ns/1ps
// Requesting master: accepts responses, stalls at random, held off on demand
module dbecc_master_model (
  input  wire logic clk,
  input  wire logic hold,
  output logic      resp_ready
);
  int seed = 32'h29B1FDA7;
  // Random stalls show that a response stands until it is taken
  always @(posedge clk) begin
    resp_ready <= !hold && (($random(seed) & 3) != 0);
  end
endmodule : dbecc_master_model

/* verification/test_dbecc_report.sv */
`timescale 1ns/1ps
module test_dbecc_report;
  logic        clk = 0, reset = 1, hold = 0, rd_valid = 0, rd_err = 0;
  logic        wb_cyc = 0, wb_stb = 0, wb_we = 0;
  logic [7:0]  wb_adr = 8'h00;
  logic [31:0] rd_data = 32'h0, rd_addr = 32'h0, wb_wdat = 32'h0;
  logic [31:0] wb_rdat, rv, last_adr, resp_data;
  logic        rd_ready, resp_valid, resp_ready, wb_ack, err_irq;
  logic [1:0]  resp_status;
  logic [33:0] expq[$];
  logic [33:0] exp_v;
  int          miscompares = 0, num_checks = 0, seed = 32'h29B1FDA7;
  always #25 clk = ~clk;
  dbecc_report u_dbecc_report (.clk(clk), .reset(reset), .ce(1'b1), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data), .rd_addr(rd_addr), .rd_double_err(rd_err),
    .resp_valid(resp_valid), .resp_ready(resp_ready), .resp_data(resp_data),
    .resp_status(resp_status), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .err_irq(err_irq));
  dbecc_master_model u_dbecc_master_model (.clk(clk), .hold(hold), .resp_ready(resp_ready));
  task automatic stop_test;
    if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task automatic check(input string nm, input logic [33:0] e, input logic [33:0] s);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  // Classic single cycle; request held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_cyc <= 1;
    wb_stb <= 1;
    wb_we <= we;
    wb_adr <= a;
    wb_wdat <= d;
    do @(posedge clk); while (wb_ack !== 1'b1);
    rv = wb_rdat;
    wb_cyc <= 0;
    wb_stb <= 0;
  endtask : wb
  // One read result; the expected response is noted when the read result is accepted
  task automatic push(input logic err);
    @(posedge clk);
    rd_valid <= 1;
    rd_data <= $random(seed);
    rd_addr <= $random(seed);
    rd_err <= err;
    do @(posedge clk); while (rd_ready !== 1'b1);
    expq.push_back({err ? dbecc_pkg::RESP_ERR : dbecc_pkg::RESP_OK, rd_data});
    if (err) last_adr = rd_addr;
    rd_valid <= 0;
  endtask : push
  // Each response taken by the master is matched against the oldest note
  always @(posedge clk) begin
    if (!reset && resp_valid === 1'b1 && resp_ready === 1'b1) begin
      exp_v = (expq.size() > 0) ? expq.pop_front() : 34'h3FFFFFFFF;
      check("resp", exp_v, {resp_status, resp_data});
    end
  end
  // Watchdog, well beyond the expected run of some 520 cycles
  initial begin
    #2000000;
    miscompares++;
    stop_test();
  end
  // Errors land in ring slot 20 on the first lap and slot 21 on the second
  initial begin
    repeat (12) @(posedge clk);
    reset <= 0;
    wb(1, dbecc_pkg::ENABLE_SET_OFS, 32'h10);
    for (int i = 0; i < 64; i++) push(i == 20 || i == 53);
    repeat (80) @(posedge clk);
    check("drained", 34'h0, 34'(expq.size()));
    wb(0, dbecc_pkg::RAW_STATUS_OFS, 32'h0);
    check("raw", 34'h10, {2'h0, rv});
    wb(0, dbecc_pkg::MASKED_STAT_OFS, 32'h0);
    check("masked", 34'h10, {2'h0, rv});
    check("irq", 34'h1, {33'h0, err_irq});
    wb(0, dbecc_pkg::ADDR_LOG_OFS, 32'h0);
    check("addr_log", {2'h0, last_adr}, {2'h0, rv});
    wb(0, dbecc_pkg::ERR_COUNT_OFS, 32'h0);
    check("err_count", 34'h2, {2'h0, rv});
    wb(0, dbecc_pkg::ENABLE_SET_OFS, 32'h0);
    check("enable", 34'h10, {2'h0, rv});
    wb(1, dbecc_pkg::RAW_STATUS_OFS, 32'h10);
    wb(0, dbecc_pkg::RAW_STATUS_OFS, 32'h0);
    check("raw_clr", 34'h0, {2'h0, rv});
    check("irq_clr", 34'h0, {33'h0, err_irq});
    wb(0, 8'hFC, 32'h0);
    check("unmapped", 34'h0, {2'h0, rv});
    hold <= 1;
    for (int i = 0; i < 32; i++) push(i[0]);
    @(posedge clk);
    check("full", 34'h0, {33'h0, rd_ready});
    hold <= 0;
    repeat (200) @(posedge clk);
    check("drained2", 34'h0, 34'(expq.size()));
    check("irq2", 34'h1, {33'h0, err_irq});
    wb(1, dbecc_pkg::ENABLE_CLR_OFS, 32'h10);
    wb(0, dbecc_pkg::MASKED_STAT_OFS, 32'h0);
    check("masked_off", 34'h0, {2'h0, rv});
    wb(0, dbecc_pkg::RAW_STATUS_OFS, 32'h0);
    check("raw2", 34'h10, {2'h0, rv});
    check("irq_off", 34'h0, {33'h0, err_irq});
    wb(0, dbecc_pkg::ERR_COUNT_OFS, 32'h0);
    check("err_count2", 34'h12, {2'h0, rv});
    stop_test();
  end
endmodule : test_dbecc_report
